// *** sgwl_pkg.sv ***
//------------------------------------------------------------------------------
// Purpose : shared constants and gain mapping for the serial gain word loader
// Assumes : one system clock at 125 MHz samples every pin
// Notes   : gain values are kept in thousandths of V/V
//------------------------------------------------------------------------------
package sgwl_pkg;

    // -------------------------------------------------------------------------
    // word layout and reset values
    // -------------------------------------------------------------------------
    localparam int          WORD_W        = 8;
    localparam int          CNT_W         = 4;
    localparam logic [7:0]  GAIN_CODE_RST = 8'h00;  // no documented power-on value
    localparam logic [7:0]  SHIFT_RST     = 8'h00;
    localparam logic [3:0]  CNT_RST       = 4'h0;
    localparam logic [3:0]  WORD_BITS     = 4'h8;   // bits in one gain word

    // -------------------------------------------------------------------------
    // gain mapping: gain = offset + step * code
    // -------------------------------------------------------------------------
    localparam int          GAIN_W         = 15;
    localparam logic [14:0] GAIN_STEP_MILLI = 15'h004D;  // 0.077 V/V per count
    localparam logic [14:0] GAIN_OFS_MILLI  = 15'h013C;  // 0.316 V/V at code 0
    localparam logic [14:0] GAIN_MAX_MILLI  = 15'h4DEF;  // 19.951 V/V at code 255
    localparam logic [7:0]  CODE_MAX        = 8'hFF;
    localparam logic [7:0]  CODE_MIN        = 8'h00;

    // -------------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int UPDATE_NS     = 30;
    localparam int SLEEP_NS      = 45;
    // longest times round down, never below one cycle
    localparam int UPDATE_CYC = (UPDATE_NS / CLK_PERIOD_NS) < 1 ? 1 : (UPDATE_NS / CLK_PERIOD_NS);
    localparam int SLEEP_CYC  = (SLEEP_NS / CLK_PERIOD_NS) < 1 ? 1 : (SLEEP_NS / CLK_PERIOD_NS);

    // code to gain in thousandths of V/V
    function automatic logic [14:0] sgwl_gain_milli(input logic [7:0] code);
        logic [14:0] prod;
        prod = GAIN_STEP_MILLI * {7'h00, code};
        return prod + GAIN_OFS_MILLI;
    endfunction

endpackage

// *** sgwl_pins_if.sv ***
//------------------------------------------------------------------------------
// Purpose : carries synchronised pin levels and edges to the loader core
// Assumes : all signals are on sys_clk
// Notes   : edges are one-cycle pulses
//------------------------------------------------------------------------------
`timescale 1ns/1ns
interface sgwl_pins_if;
    logic sclk_rise;    // serial clock rising edge pulse
    logic serial_gain_in_s;      // synchronised serial data
    logic load_n_s;     // synchronised load enable, active low
    logic load_rise;    // load enable rising edge pulse
    logic load_fall;    // load enable falling edge pulse
    logic sleep_n_s;    // synchronised power-down, active low

    modport sync (output sclk_rise, serial_gain_in_s, load_n_s, load_rise, load_fall, sleep_n_s);
    modport core (input  sclk_rise, serial_gain_in_s, load_n_s, load_rise, load_fall, sleep_n_s);
endinterface

// *** sgwl_sync.sv ***
//------------------------------------------------------------------------------
// Purpose : two-flop synchronisers for the four pins, edge finders for serial clock and load enable
// Assumes : pins are asynchronous to sys_clk
// Notes   : edges are found on the second stage only
//------------------------------------------------------------------------------
`timescale 1ns/1ns
module sgwl_sync
    import sgwl_pkg::*;
(
    input  wire logic   sys_clk,
    input  wire logic   sys_rst,
    input  wire logic   serial_clk,
    input  wire logic   serial_gain_in,
    input  wire logic   load_enable_n,
    input  wire logic   amp_sleep_n,
    sgwl_pins_if.sync   pins
);
    // bit order: 3 sleep, 2 load, 1 data, 0 clock
    localparam logic [3:0] SYNC_RST = 4'hC;  // idle pins: load high, awake

    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    logic [3:0] prev_ff;
    logic [3:0] nxt_meta;
    logic [3:0] nxt_sync;
    logic [3:0] nxt_prev;

    // -------------------------------------------------------------------------
    // next stage values; first stage feeds only the second
    // -------------------------------------------------------------------------
    always_comb begin
        nxt_meta = {amp_sleep_n, load_enable_n, serial_gain_in, serial_clk};
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    // register stages
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_ff <= SYNC_RST;
            sync_ff <= SYNC_RST;
            prev_ff <= SYNC_RST;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    // edges from settled stage against its delayed copy
    assign pins.sclk_rise = sync_ff[0] & ~prev_ff[0];
    assign pins.serial_gain_in_s   = sync_ff[1];
    assign pins.load_n_s  = sync_ff[2];
    assign pins.load_rise = sync_ff[2] & ~prev_ff[2];
    assign pins.load_fall = ~sync_ff[2] & prev_ff[2];
    assign pins.sleep_n_s = sync_ff[3];
endmodule

// *** sgwl_loader.sv ***
//------------------------------------------------------------------------------
// Purpose : serial gain word loader: shift register, data latch, amp mode
// Assumes : serial clock period well above four sys_clk cycles
// Notes   : pins are oversampled; latency from pin to output is three cycles
//------------------------------------------------------------------------------
// Functional notes
// (R1) gain word is 8 bits, shifted MSB first on serial clock rising edges
// (R2) latched gain holds while load enable is low
// (R3) controller gives exactly eight clocks with load low, then raises it
// (R4) load enable rising edge copies shift register into the gain latch
// (R5) with load enable high, serial clock and data are ignored
// (R6) code is unsigned: all ones maximum gain, all zeros minimum
// (R7) gain equals fixed offset plus fixed step times latched code
// (R8) power-down input high: forward amplifier on, reverse off
// (R9) power-down input low: forward amplifier off, reverse amplifier on
// (R10) power-down never disturbs the latched gain
// (R11) load enable falling edge freezes latch and arms the shift register
// (R12) new gain takes effect within about 30 ns of load rising
// (R13) power-down acts at any time; output off within about 45 ns
// (R14) no power-on gain; controller loads a known word first; here reset loads code 0 (0.316 V/V)
`timescale 1ns/1ns
module sgwl_loader
    import sgwl_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              serial_clk,
    input  wire logic              serial_gain_in,
    input  wire logic              load_enable_n,
    input  wire logic              amp_sleep_n,
    output logic [WORD_W-1:0]      gain_code_ff,
    output logic [GAIN_W-1:0]      gain_milli_ff,
    output logic                   gain_update_ff,
    output logic                   fwd_amp_en_ff,
    output logic                   rev_amp_en_ff,
    output logic [CNT_W-1:0]       bit_count_ff,
    output logic                   word_full_ff
);
    localparam int UPD_LAT = UPDATE_CYC;
    localparam int SLP_LAT = SLEEP_CYC;

    sgwl_pins_if pins ();

    // -------------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------------
    sgwl_sync u_sync (
        .sys_clk        (sys_clk),
        .sys_rst        (sys_rst),
        .serial_clk     (serial_clk),
        .serial_gain_in (serial_gain_in),
        .load_enable_n  (load_enable_n),
        .amp_sleep_n    (amp_sleep_n),
        .pins           (pins.sync)
    );

    logic [WORD_W-1:0] shift_ff;
    logic [WORD_W-1:0] nxt_shift;
    logic [CNT_W-1:0]  nxt_bit_count;
    logic              nxt_word_full;
    logic [WORD_W-1:0] nxt_gain_code;
    logic [GAIN_W-1:0] nxt_gain_milli;
    logic              nxt_gain_update;
    logic              nxt_fwd_amp_en;
    logic              nxt_rev_amp_en;
    logic              shift_en;

    // -------------------------------------------------------------------------
    // shift register and bit counter
    // -------------------------------------------------------------------------
    // shifting only while load is low; the gated clock is modelled as enable
    assign shift_en = ~pins.load_n_s & pins.sclk_rise;  // (R5)

    always_comb begin
        nxt_shift     = shift_ff;
        nxt_bit_count = bit_count_ff;
        if (pins.load_fall) begin
            nxt_bit_count = CNT_RST;  // (R11)
        end
        // a clock rise in the load fall cycle still counts as the first bit
        if (shift_en) begin
            nxt_shift = {shift_ff[WORD_W-2:0], pins.serial_gain_in_s};  // (R1)
            // count saturates; extra clocks still shift, last eight win (R3)
            if (nxt_bit_count != WORD_BITS) begin
                nxt_bit_count = nxt_bit_count + 4'h1;
            end
        end
        nxt_word_full = (nxt_bit_count == WORD_BITS);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            shift_ff     <= SHIFT_RST;
            bit_count_ff <= CNT_RST;
            word_full_ff <= 1'b0;
        end else begin
            shift_ff     <= nxt_shift;
            bit_count_ff <= nxt_bit_count;
            word_full_ff <= nxt_word_full;
        end
    end

    // -------------------------------------------------------------------------
    // data latch and gain mapping
    // -------------------------------------------------------------------------
    // latch loads once per rising edge; equals transparency since the
    // shift register cannot move while load is high
    always_comb begin
        nxt_gain_code   = gain_code_ff;  // (R2)
        nxt_gain_milli  = gain_milli_ff;
        nxt_gain_update = 1'b0;
        if (pins.load_rise) begin
            nxt_gain_code   = shift_ff;  // (R4)
            nxt_gain_milli  = sgwl_gain_milli(shift_ff);  // (R6) (R7)
            nxt_gain_update = 1'b1;  // (R12)
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gain_code_ff   <= GAIN_CODE_RST;
            gain_milli_ff  <= GAIN_OFS_MILLI;
            gain_update_ff <= 1'b0;
        end else begin
            gain_code_ff   <= nxt_gain_code;
            gain_milli_ff  <= nxt_gain_milli;
            gain_update_ff <= nxt_gain_update;
        end
    end

    // -------------------------------------------------------------------------
    // amplifier mode
    // -------------------------------------------------------------------------
    // mode follows the level only; latch is not touched here (R10)
    always_comb begin
        nxt_fwd_amp_en = pins.sleep_n_s;   // (R8) (R13)
        nxt_rev_amp_en = ~pins.sleep_n_s;  // (R9)
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fwd_amp_en_ff <= 1'b1;
            rev_amp_en_ff <= 1'b0;
        end else begin
            fwd_amp_en_ff <= nxt_fwd_amp_en;
            rev_amp_en_ff <= nxt_rev_amp_en;
        end
    end

    // -------------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------------
    property p_shift_msb_first;
        @(posedge sys_clk) disable iff (sys_rst)
        shift_en |=>
            shift_ff == {$past(shift_ff[WORD_W-2:0]), $past(pins.serial_gain_in_s)};
    endproperty
    a_shift_msb_first: assert property (p_shift_msb_first) // (R1)
        else $error("shift register did not take serial bit at lsb");

    property p_latch_holds;
        @(posedge sys_clk) disable iff (sys_rst)
        (!pins.load_n_s && !pins.load_rise) |=> $stable(gain_code_ff);
    endproperty
    a_latch_holds: assert property (p_latch_holds) // (R2)
        else $error("gain changed while load enable low");

    property p_latch_loads;
        @(posedge sys_clk) disable iff (sys_rst)
        pins.load_rise |=> (gain_code_ff == $past(shift_ff)) && gain_update_ff;
    endproperty
    a_latch_loads: assert property (p_latch_loads) // (R4)
        else $error("gain latch missed shift register on load rise");

    property p_shift_gated;
        @(posedge sys_clk) disable iff (sys_rst)
        pins.load_n_s |=> $stable(shift_ff);
    endproperty
    a_shift_gated: assert property (p_shift_gated) // (R5)
        else $error("shift register moved while load enable high");

    property p_code_extremes;
        @(posedge sys_clk) disable iff (sys_rst)
        (gain_code_ff == CODE_MAX |-> gain_milli_ff == GAIN_MAX_MILLI) and
        (gain_code_ff == CODE_MIN |-> gain_milli_ff == GAIN_OFS_MILLI);
    endproperty
    a_code_extremes: assert property (p_code_extremes) // (R6)
        else $error("gain extremes do not match code extremes");

    property p_gain_linear;
        @(posedge sys_clk) disable iff (sys_rst)
        pins.load_rise ##1 (gain_code_ff != CODE_MIN) |->
            gain_milli_ff - GAIN_STEP_MILLI == sgwl_gain_milli(gain_code_ff - 8'h01);
    endproperty
    a_gain_linear: assert property (p_gain_linear) // (R7)
        else $error("gain step per code count is wrong");

    property p_forward_mode;
        @(posedge sys_clk) disable iff (sys_rst)
        pins.sleep_n_s |=> fwd_amp_en_ff && !rev_amp_en_ff;
    endproperty
    a_forward_mode: assert property (p_forward_mode) // (R8)
        else $error("forward mode not selected with power-down high");

    property p_reverse_mode;
        @(posedge sys_clk) disable iff (sys_rst)
        !pins.sleep_n_s |=> !fwd_amp_en_ff && rev_amp_en_ff;
    endproperty
    a_reverse_mode: assert property (p_reverse_mode) // (R9)
        else $error("reverse mode not selected with power-down low");

    property p_sleep_keeps_gain;
        @(posedge sys_clk) disable iff (sys_rst)
        ($changed(pins.sleep_n_s) && !pins.load_rise) |=> $stable(gain_milli_ff);
    endproperty
    a_sleep_keeps_gain: assert property (p_sleep_keeps_gain) // (R10)
        else $error("power-down disturbed the latched gain");

    property p_fall_arms;
        @(posedge sys_clk) disable iff (sys_rst)
        pins.load_fall |=>
            (bit_count_ff == ($past(shift_en) ? 4'h1 : CNT_RST)) && $stable(gain_code_ff);
    endproperty
    a_fall_arms: assert property (p_fall_arms) // (R11)
        else $error("load fall did not restart the word");

    property p_update_time;
        @(posedge sys_clk) disable iff (sys_rst)
        ($rose(load_enable_n) ##1 load_enable_n) |-> ##[0:UPD_LAT] gain_update_ff;
    endproperty
    a_update_time: assert property (p_update_time) // (R12)
        else $error("gain update later than allowed");

    property p_sleep_time;
        @(posedge sys_clk) disable iff (sys_rst)
        ($fell(amp_sleep_n) ##1 !amp_sleep_n ##1 !amp_sleep_n) |->
            ##[0:SLP_LAT] !fwd_amp_en_ff;
    endproperty
    a_sleep_time: assert property (p_sleep_time) // (R13)
        else $error("output not switched off in time after power-down");

endmodule

// *** sgwl_host_model.sv ***
// Purpose : behavioural host driving the three-wire gain word interface
// Assumes : link clock of 64 ns period, stopped between frames
// Notes   : the bench calls the tasks; the gap argument makes a slow host
`timescale 1ns/1ns
module sgwl_host_model (
    output logic serial_clk,
    output logic serial_gain_in,
    output logic load_enable_n
);
    // ------------------------------------------------------------------
    // idle pin levels
    // ------------------------------------------------------------------
    // data starts low; load enable idles high
    initial begin
        serial_clk     = 1'b0;
        serial_gain_in = 1'b0;
        load_enable_n  = 1'b1;
    end

    // ------------------------------------------------------------------
    // frame tasks
    // ------------------------------------------------------------------
    // load low, then eight bits msb first, data set half a period early
    task automatic shift_word(input logic [7:0] w, input int gap);
        load_enable_n = 1'b0;
        #32;
        for (int i = 7; i >= 0; i--) begin
            serial_gain_in = w[i];
            #(32 + gap);
            serial_clk = 1'b1;
            #32;
            serial_clk = 1'b0;
        end
        #32;
    endtask

    // raise load; the data line is no longer meaningful, so it flips
    task automatic end_frame();
        load_enable_n  = 1'b1;
        serial_gain_in = ~serial_gain_in;
    endtask

    // load low with no clocks; the shift register must keep its word
    task automatic empty_frame();
        load_enable_n = 1'b0;
        #64;
    endtask

    // clocks while load is high must be ignored by the device
    task automatic stray_clocks(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            serial_gain_in = w[i];
            #32;
            serial_clk = 1'b1;
            #32;
            serial_clk = 1'b0;
        end
    endtask
endmodule

// *** tb_top.sv ***
// Purpose : self-checking bench for the serial gain word loader
// Assumes : sys_clk 8 ns, link clock 64 ns from the host model
// Notes   : expected codes queue up at load rise; a monitor checks them
`timescale 1ns/1ns
module tb_top;
    import sgwl_pkg::*;
    logic              sys_clk;
    logic              sys_rst;
    logic              serial_clk;
    logic              serial_gain_in;
    logic              load_enable_n;
    logic              amp_sleep_n;
    logic [7:0]        gain_code_ff;
    logic [14:0]       gain_milli_ff;
    logic              gain_update_ff;
    logic              fwd_amp_en_ff;
    logic              rev_amp_en_ff;
    logic [3:0]        bit_count_ff;
    logic              word_full_ff;
    logic [7:0]        exp_q[$];
    logic [7:0]        last_code;
    int                miscompares;
    int                check_count;
    int                seed_val;

    sgwl_host_model host_u (.serial_clk(serial_clk), .serial_gain_in(serial_gain_in),
                            .load_enable_n(load_enable_n));
    sgwl_loader dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
        .serial_gain_in(serial_gain_in), .load_enable_n(load_enable_n),
        .amp_sleep_n(amp_sleep_n), .gain_code_ff(gain_code_ff),
        .gain_milli_ff(gain_milli_ff), .gain_update_ff(gain_update_ff),
        .fwd_amp_en_ff(fwd_amp_en_ff), .rev_amp_en_ff(rev_amp_en_ff),
        .bit_count_ff(bit_count_ff), .word_full_ff(word_full_ff));

    // ------------------------------------------------------------------
    // clock, compares, verdict
    // ------------------------------------------------------------------
    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;

    task automatic chk_word(input string name, input logic [14:0] exp, input logic [14:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // result monitor
    // ------------------------------------------------------------------
    // every latch load must match the oldest queued word
    always @(posedge sys_clk) begin
        if (gain_update_ff === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk_bit("unexpected_update", 1'b0, 1'b1);
            end else begin
                chk_word("gain_code", {7'h00, exp_q[0]}, {7'h00, gain_code_ff});
                chk_word("gain_milli", 15'h013C + 15'h004D * {7'h00, exp_q[0]}, gain_milli_ff);
                void'(exp_q.pop_front());
            end
        end
    end

    // ------------------------------------------------------------------
    // load one word and time the update
    // ------------------------------------------------------------------
    // latency counts sys_clk edges after the load pin rises
    task automatic load_word(input logic [7:0] c, input int gap);
        logic [7:0] old;
        int         lat;
        old = gain_code_ff;
        host_u.shift_word(c, gap);
        chk_word("held_code", {7'h00, old}, {7'h00, gain_code_ff});
        chk_word("bit_count", 15'h0008, {11'h000, bit_count_ff});
        chk_bit("word_full", 1'b1, word_full_ff);
        exp_q.push_back(c);
        last_code = c;
        host_u.end_frame();
        lat = 0;
        while (lat < 4 && gain_update_ff !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            lat++;
        end
        chk_bit("update_in_time", 1'b1, lat <= 3);
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        miscompares = 0;
        check_count = 0;
        sys_rst     = 1'b1;
        amp_sleep_n = 1'b1;
        seed_val    = $urandom(90257);
        repeat (6) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk_word("reset_milli", 15'h013C, gain_milli_ff);
        chk_bit("reset_fwd", 1'b1, fwd_amp_en_ff);
        // end points, single bits, then random words from fast and slow hosts
        load_word(8'hFF, 0);
        load_word(8'h00, 40);
        load_word(8'h01, 0);
        load_word(8'h80, 0);
        for (int i = 0; i < 6; i++) begin
            load_word(8'($urandom_range(255)), (i % 2) * 40);
        end
        // clocks with load high leave the shift register and latch alone
        host_u.stray_clocks(8'hA5);
        #64;
        chk_word("stray_count", 15'h0008, {11'h000, bit_count_ff});
        chk_word("stray_code", {7'h00, last_code}, {7'h00, gain_code_ff});
        // an empty frame reloads the untouched shift register
        host_u.empty_frame();
        chk_word("empty_count", 15'h0000, {11'h000, bit_count_ff});
        chk_bit("empty_full", 1'b0, word_full_ff);
        exp_q.push_back(last_code);
        host_u.end_frame();
        repeat (6) @(posedge sys_clk);
        #1;
        chk_word("reload_code", {7'h00, last_code}, {7'h00, gain_code_ff});
        // sleep, load while asleep, then wake
        amp_sleep_n = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        chk_bit("sleep_fwd", 1'b0, fwd_amp_en_ff);
        chk_bit("sleep_rev", 1'b1, rev_amp_en_ff);
        load_word(8'h3C, 0);
        chk_bit("asleep_fwd", 1'b0, fwd_amp_en_ff);
        @(posedge sys_clk);
        #1;
        amp_sleep_n = 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
        chk_bit("wake_fwd", 1'b1, fwd_amp_en_ff);
        chk_bit("wake_rev", 1'b0, rev_amp_en_ff);
        chk_word("wake_code", 15'h003C, {7'h00, gain_code_ff});
        chk_word("queue_left", 15'h0000, 15'(exp_q.size()));
        test_done();
    end

    // ------------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------------
    // tests take about 9 us; 100 us means a hang
    initial begin
        #100000;
        miscompares++;
        test_done();
    end
endmodule
